//--- hw/ppm_pkg.sv
// Package of constants and types for the panel power management pin logic
package ppm_pkg;

    // Register byte offsets
    localparam logic [7:0] PPM_OFS_CTRL     = 8'h00; // power_mgmt_ctrl
    localparam logic [7:0] PPM_OFS_DEBOUNCE = 8'h04; // suspend_debounce_cfg
    localparam logic [7:0] PPM_OFS_SEQCFG   = 8'h08; // seq_misc_cfg
    localparam logic [7:0] PPM_OFS_TIMER    = 8'h0c; // power-down timeout
    localparam logic [7:0] PPM_OFS_STATUS   = 8'h10; // sticky events, read only
    localparam logic [7:0] PPM_OFS_IRQ_EN   = 8'h14; // event enables
    localparam logic [7:0] PPM_OFS_IRQ_CLR  = 8'h18; // write one to clear
    localparam logic [7:0] PPM_OFS_STATE    = 8'h1c; // live state, read only

    // power_mgmt_ctrl fields
    localparam int PPM_CTRL_STBY_DIR = 7;
    localparam int PPM_CTRL_LCD_EN   = 6;
    localparam int PPM_CTRL_CRT_EN   = 5;
    localparam int PPM_CTRL_ACT_MASK = 4;
    localparam int PPM_CTRL_SUSP_OFF = 3; // 1: suspend only turns panel off
    localparam int PPM_CTRL_STBY_SW  = 2; // software standby request
    // seq_misc_cfg field
    localparam int PPM_SEQ_SUSP_POL  = 3; // 0: active high
    // Event bits
    localparam int PPM_EV_ACTIVITY   = 0;
    localparam int PPM_EV_PANEL_RST  = 1;
    localparam int PPM_EV_TIMEOUT    = 2;
    localparam int PPM_EV_STANDBY    = 3;
    localparam int PPM_EV_SUSPEND    = 4;
    localparam int PPM_EV_SEQ_DONE   = 5;
    localparam int PPM_EV_W          = 6;

    // Reset values
    localparam logic [7:0]  PPM_CTRL_RST     = 8'h00;
    localparam logic [3:0]  PPM_DEBOUNCE_RST = 4'h0;
    localparam logic [7:0]  PPM_SEQCFG_RST   = 8'h00;
    localparam logic [15:0] PPM_TIMER_RST    = 16'h0000; // zero disables the timer

    // Time base: one tick per microsecond at 100 MHz
    localparam int PPM_CLK_MHZ    = 100;
    localparam int PPM_TICK_NS    = 1000;
    localparam int PPM_TICK_CYC   = PPM_TICK_NS * PPM_CLK_MHZ / 1000;
    // Debounce ticks per field step, and power sequence step delay in ticks
    localparam int PPM_DEB_STEP   = 1000;
    localparam int PPM_SEQ_STEP   = 1000;

    typedef enum logic [2:0] {
        PPM_OFF, PPM_UP_VCC, PPM_UP_VEE, PPM_ON, PPM_DN_BACK, PPM_DN_VEE
    } ppm_state_t;

    // Synchronised pins travel together
    typedef struct packed {
        logic activity;
        logic panel_reset_n;
        logic standby;
        logic suspend;
        logic ac_power;
    } ppm_pins_t;

endpackage : ppm_pkg

//--- hw/ppm_top.sv
// Panel power management pin logic with Wishbone register slave
// What this block does
// RULE_01: If unmasked, each activity rising edge restarts the power-down timer.
// RULE_02: Backlight enable is driven as one step of panel power sequence.
// RULE_03: Panel logic-power enable is driven as a power sequence step.
// RULE_04: Panel bias-power enable is driven as a power sequence step.
// RULE_05: Panel reset falling edge clears LCD and CRT enable bits 6 and 5.
// RULE_06: That clearing starts panel power-down and halts memory refresh.
// RULE_07: Panel reset rising edge leaves enables cleared; software rewrites them.
// RULE_08: AC power high freezes the power-down timer; no timeout power-down.
// RULE_09: When AC power drops, the timer resumes from its held count.
// RULE_10: Control bit 7 sets standby pin direction: 0 input, 1 output.
// RULE_11: Standby pin as input rising high starts standby power-down.
// RULE_12: Standby pin as output is high in standby, low otherwise.
// RULE_13: Suspend polarity comes from bit 3 of the sequencer config register.
// RULE_14: Suspend debounce interval comes from a four-bit field, bits 3..0.
// RULE_15: Debounced suspend enters hardware suspend or turns the panel off.
// RULE_16: After reset, suspend is active high.
// RULE_17: Suspend counts only after holding active for the whole debounce interval.
// RULE_18: Activity, panel reset and standby edges use synchronised sample compares.
`timescale 1ns/100ps
module ppm_top
    import ppm_pkg::*;
#(
    parameter int DEB_STEP_TICKS = PPM_DEB_STEP,
    parameter int SEQ_STEP_TICKS = PPM_SEQ_STEP
)(
    input  wire logic        I_CLOCK,
    input  wire logic        I_RST,
    input  wire logic        I_WB_CYC,
    input  wire logic        I_WB_STB,
    input  wire logic        I_WB_WE,
    input  wire logic [7:0]  I_WB_ADR,
    input  wire logic [3:0]  I_WB_SEL,
    input  wire logic [31:0] I_WB_DAT,
    output logic      [31:0] O_WB_DAT,
    output logic             O_WB_ACK,
    input  wire logic        I_ACTIVITY_SENSE_IN,
    input  wire logic        I_PANEL_RESET_N,
    input  wire logic        I_AC_POWER_PRESENT,
    input  wire logic        I_SUSPEND,
    input  wire logic        I_STANDBY,
    output logic             O_STANDBY,
    output logic             O_STANDBY_OE_N,
    output logic             O_PANEL_BACKLIGHT_EN,
    output logic             O_PANEL_LOGIC_POWER_EN,
    output logic             O_PANEL_BIAS_POWER_EN,
    output logic             O_REFRESH_EN,
    output logic             O_SUSPEND_MODE,
    output logic             O_IRQ
);

    // Width of the larger tick counters
    localparam int CW = 24;

    function automatic logic rise(input logic now, input logic prev);
        return now & ~prev;
    endfunction : rise

    ppm_pins_t  meta_r;
    ppm_pins_t  sync_r;
    ppm_pins_t  prev_r;
    logic [7:0]  ctrl_r;
    logic [3:0]  deb_cfg_r;
    logic [7:0]  seq_cfg_r;
    logic [15:0] timeout_r;
    logic [PPM_EV_W-1:0] status_r;
    logic [PPM_EV_W-1:0] irq_en_r;
    logic [PPM_EV_W-1:0] event_nxt;
    logic [7:0]  tick_cnt_r;
    logic        tick_r;
    logic [15:0] idle_cnt_r;
    logic [CW-1:0] deb_cnt_r;
    logic        susp_active_r;
    logic [CW-1:0] seq_cnt_r;
    logic        standby_r;
    ppm_state_t  state_r;
    logic        wb_req;
    logic        wb_wr;
    logic        act_edge;
    logic        prst_fall;
    logic        stby_rise;
    logic        susp_level;
    logic        timeout_hit;
    logic        panel_want;
    logic        seq_done;

    // Two-stage synchroniser; only sync_r and prev_r are read by logic
    always_ff @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            meta_r <= '{panel_reset_n: 1'b1, default: 1'b0};
            sync_r <= '{panel_reset_n: 1'b1, default: 1'b0};
            prev_r <= '{panel_reset_n: 1'b1, default: 1'b0};
        end
        else
        begin
            meta_r <= '{activity: I_ACTIVITY_SENSE_IN, panel_reset_n: I_PANEL_RESET_N,
                        standby: I_STANDBY, suspend: I_SUSPEND, ac_power: I_AC_POWER_PRESENT};
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // Edge detection against previous sample
    assign act_edge  = rise(sync_r.activity, prev_r.activity);               // see RULE_18
    assign prst_fall = rise(prev_r.panel_reset_n, sync_r.panel_reset_n);     // see RULE_18
    assign stby_rise = ~ctrl_r[PPM_CTRL_STBY_DIR]
                       & rise(sync_r.standby, prev_r.standby);               // see RULE_11
    assign susp_level = sync_r.suspend ^ seq_cfg_r[PPM_SEQ_SUSP_POL];        // see RULE_13

    // Wishbone classic decode
    assign wb_req = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
    assign wb_wr  = wb_req & I_WB_WE & I_WB_SEL[0];

    // Bus ack and read data
    always_ff @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            O_WB_ACK <= 1'b0;
            O_WB_DAT <= 32'h0000_0000;
        end
        else
        begin
            O_WB_ACK <= wb_req;
            O_WB_DAT <= 32'h0000_0000;
            if (wb_req && !I_WB_WE)
            begin
                unique case (I_WB_ADR)
                    PPM_OFS_CTRL:     O_WB_DAT[7:0] <= ctrl_r;
                    PPM_OFS_DEBOUNCE: O_WB_DAT[3:0] <= deb_cfg_r;
                    PPM_OFS_SEQCFG:   O_WB_DAT[7:0] <= seq_cfg_r;
                    PPM_OFS_TIMER:    O_WB_DAT[15:0] <= timeout_r;
                    PPM_OFS_STATUS:   O_WB_DAT[PPM_EV_W-1:0] <= status_r;
                    PPM_OFS_IRQ_EN:   O_WB_DAT[PPM_EV_W-1:0] <= irq_en_r;
                    PPM_OFS_STATE:    O_WB_DAT[7:0] <= {susp_active_r, standby_r, 3'(state_r),
                                                        O_PANEL_BACKLIGHT_EN, O_PANEL_BIAS_POWER_EN,
                                                        O_PANEL_LOGIC_POWER_EN};
                    default:          O_WB_DAT <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Control register; panel reset fall wins over a write
    always_ff @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            ctrl_r <= PPM_CTRL_RST;
        end
        else
        begin
            if (wb_wr && I_WB_ADR == PPM_OFS_CTRL)
            begin
                ctrl_r <= I_WB_DAT[7:0];          // see RULE_07
            end
            if (prst_fall)
            begin
                ctrl_r[PPM_CTRL_LCD_EN] <= 1'b0;  // see RULE_05
                ctrl_r[PPM_CTRL_CRT_EN] <= 1'b0;  // see RULE_05
            end
        end
    end

    // Configuration registers
    always_ff @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            deb_cfg_r <= PPM_DEBOUNCE_RST;
            seq_cfg_r <= PPM_SEQCFG_RST;          // see RULE_16
            timeout_r <= PPM_TIMER_RST;
            irq_en_r  <= '0;
        end
        else if (wb_wr)
        begin
            unique case (I_WB_ADR)
                PPM_OFS_DEBOUNCE: deb_cfg_r <= I_WB_DAT[3:0];   // see RULE_14
                PPM_OFS_SEQCFG:   seq_cfg_r <= I_WB_DAT[7:0];   // see RULE_13
                PPM_OFS_TIMER:    timeout_r <= I_WB_DAT[15:0];
                PPM_OFS_IRQ_EN:   irq_en_r  <= I_WB_DAT[PPM_EV_W-1:0];
                default:          ;
            endcase
        end
    end

    // Microsecond tick divider
    always_ff @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            tick_cnt_r <= 8'h00;
            tick_r     <= 1'b0;
        end
        else
        begin
            tick_r     <= (tick_cnt_r == 8'(PPM_TICK_CYC - 1));
            tick_cnt_r <= (tick_cnt_r == 8'(PPM_TICK_CYC - 1)) ? 8'h00 : tick_cnt_r + 8'h01;
        end
    end

    // Power-down idle timer, counted in ticks
    assign timeout_hit = (timeout_r != 16'h0000) && (idle_cnt_r == timeout_r)
                         && !(act_edge && ctrl_r[PPM_CTRL_ACT_MASK])         // see RULE_01
                         && !sync_r.ac_power;                                // see RULE_08
    always_ff @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            idle_cnt_r <= 16'h0000;
        end
        else if (act_edge && ctrl_r[PPM_CTRL_ACT_MASK])
        begin
            idle_cnt_r <= 16'h0000;               // see RULE_01
        end
        else if (sync_r.ac_power)
        begin
            idle_cnt_r <= idle_cnt_r;             // see RULE_08
        end
        else if (tick_r && idle_cnt_r != timeout_r)
        begin
            idle_cnt_r <= idle_cnt_r + 16'h0001;  // see RULE_09
        end
    end

    // Suspend debounce: restart on any inactive sample
    always_ff @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            deb_cnt_r     <= '0;
            susp_active_r <= 1'b0;
        end
        else if (!susp_level)
        begin
            deb_cnt_r     <= '0;                  // see RULE_17
            susp_active_r <= 1'b0;
        end
        else if (deb_cnt_r >= CW'(deb_cfg_r) * CW'(DEB_STEP_TICKS))
        begin
            susp_active_r <= 1'b1;                // see RULE_17
        end
        else if (tick_r)
        begin
            deb_cnt_r <= deb_cnt_r + CW'(1);
        end
    end

    // Standby mode state
    always_ff @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            standby_r <= 1'b0;
        end
        else if (stby_rise || timeout_hit || ctrl_r[PPM_CTRL_STBY_SW])
        begin
            standby_r <= 1'b1;                    // see RULE_11
        end
        else if (act_edge && ctrl_r[PPM_CTRL_ACT_MASK])
        begin
            standby_r <= 1'b0;
        end
    end

    // Panel wanted on only while enabled and no power saving mode is active
    assign panel_want = ctrl_r[PPM_CTRL_LCD_EN] & ~standby_r & ~susp_active_r;  // see RULE_15
    assign seq_done   = tick_r && seq_cnt_r >= CW'(SEQ_STEP_TICKS);

    // Panel power sequencer: logic, bias, backlight up; reverse down
    always_ff @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            state_r   <= PPM_OFF;
            seq_cnt_r <= '0;
        end
        else
        begin
            seq_cnt_r <= tick_r ? seq_cnt_r + CW'(1) : seq_cnt_r;
            unique case (state_r)
                PPM_OFF:
                    if (panel_want)
                    begin
                        state_r   <= PPM_UP_VCC;
                        seq_cnt_r <= '0;
                    end
                PPM_UP_VCC:
                    if (!panel_want)
                        state_r <= PPM_OFF;
                    else if (seq_done)
                    begin
                        state_r   <= PPM_UP_VEE;
                        seq_cnt_r <= '0;
                    end
                PPM_UP_VEE:
                    if (!panel_want || seq_done)
                    begin
                        state_r   <= panel_want ? PPM_ON : PPM_DN_VEE;
                        seq_cnt_r <= '0;
                    end
                PPM_ON:
                    if (!panel_want)
                    begin
                        state_r   <= PPM_DN_BACK;         // see RULE_06
                        seq_cnt_r <= '0;
                    end
                PPM_DN_BACK:
                    if (seq_done)
                    begin
                        state_r   <= PPM_DN_VEE;
                        seq_cnt_r <= '0;
                    end
                PPM_DN_VEE:
                    if (seq_done)
                    begin
                        state_r   <= PPM_OFF;
                        seq_cnt_r <= '0;
                    end
                default:
                    state_r <= PPM_OFF;
            endcase
        end
    end

    // Registered pin outputs
    always_ff @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            O_PANEL_BACKLIGHT_EN   <= 1'b0;
            O_PANEL_LOGIC_POWER_EN <= 1'b0;
            O_PANEL_BIAS_POWER_EN  <= 1'b0;
            O_REFRESH_EN           <= 1'b0;
            O_SUSPEND_MODE         <= 1'b0;
            O_STANDBY              <= 1'b0;
            O_STANDBY_OE_N         <= 1'b1;
        end
        else
        begin
            O_PANEL_BACKLIGHT_EN   <= (state_r == PPM_ON);                          // see RULE_02
            O_PANEL_LOGIC_POWER_EN <= (state_r != PPM_OFF);                         // see RULE_03
            O_PANEL_BIAS_POWER_EN  <= (state_r == PPM_UP_VEE) || (state_r == PPM_ON)
                                      || (state_r == PPM_DN_BACK);                  // see RULE_04
            O_REFRESH_EN           <= ctrl_r[PPM_CTRL_LCD_EN] | ctrl_r[PPM_CTRL_CRT_EN]; // see RULE_06
            O_SUSPEND_MODE         <= susp_active_r & ~ctrl_r[PPM_CTRL_SUSP_OFF];   // see RULE_15
            O_STANDBY              <= standby_r;                                    // see RULE_12
            O_STANDBY_OE_N         <= ~ctrl_r[PPM_CTRL_STBY_DIR];                   // see RULE_10
        end
    end

    // Event pulses for the status register
    always_comb
    begin
        event_nxt = '0;
        event_nxt[PPM_EV_ACTIVITY]  = act_edge;
        event_nxt[PPM_EV_PANEL_RST] = prst_fall;
        event_nxt[PPM_EV_TIMEOUT]   = timeout_hit & ~standby_r;
        event_nxt[PPM_EV_STANDBY]   = stby_rise;
        event_nxt[PPM_EV_SUSPEND]   = susp_level && !susp_active_r
                                      && deb_cnt_r >= CW'(deb_cfg_r) * CW'(DEB_STEP_TICKS);
        event_nxt[PPM_EV_SEQ_DONE]  = (state_r == PPM_DN_VEE) && seq_done;
    end

    // Sticky status, set wins over clear, and interrupt line
    always_ff @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            status_r <= '0;
            O_IRQ    <= 1'b0;
        end
        else
        begin
            if (wb_wr && I_WB_ADR == PPM_OFS_IRQ_CLR)
                status_r <= (status_r & ~I_WB_DAT[PPM_EV_W-1:0]) | event_nxt;
            else
                status_r <= status_r | event_nxt;
            O_IRQ <= |(status_r & irq_en_r);
        end
    end

endmodule : ppm_top

//--- tb/ppm_props.sv
// Port checks for the panel power management pin logic
`timescale 1ns/100ps
module ppm_props
    import ppm_pkg::*;
#(
    parameter int DEB_STEP_TICKS = PPM_DEB_STEP,
    parameter int SEQ_STEP_TICKS = PPM_SEQ_STEP
)(
    input wire logic        I_CLOCK,
    input wire logic        I_RST,
    input wire logic        I_WB_CYC,
    input wire logic        I_WB_STB,
    input wire logic        I_WB_WE,
    input wire logic [7:0]  I_WB_ADR,
    input wire logic [3:0]  I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    input wire logic [31:0] O_WB_DAT,
    input wire logic        O_WB_ACK,
    input wire logic        I_ACTIVITY_SENSE_IN,
    input wire logic        I_PANEL_RESET_N,
    input wire logic        I_AC_POWER_PRESENT,
    input wire logic        I_SUSPEND,
    input wire logic        I_STANDBY,
    input wire logic        O_STANDBY,
    input wire logic        O_STANDBY_OE_N,
    input wire logic        O_PANEL_BACKLIGHT_EN,
    input wire logic        O_PANEL_LOGIC_POWER_EN,
    input wire logic        O_PANEL_BIAS_POWER_EN,
    input wire logic        O_REFRESH_EN,
    input wire logic        O_SUSPEND_MODE,
    input wire logic        O_IRQ
);
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);
    // Each power-up step holds back the next one
    sequence s_bias_wait;
        !O_PANEL_BIAS_POWER_EN [*8];
    endsequence
    sequence s_back_wait;
        !O_PANEL_BACKLIGHT_EN [*8];
    endsequence
    // Bus answer timing
    ack_once_a: assert property (O_WB_ACK |=> !O_WB_ACK) else $error("ack held too long");
    ack_answer_a: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK) else $error("no ack");
    dat_idle_a: assert property (!O_WB_ACK |-> O_WB_DAT == 32'h0) else $error("read data outside ack");
    // Power sequence order and spacing
    bias_needs_logic_a: assert property (O_PANEL_BIAS_POWER_EN |-> O_PANEL_LOGIC_POWER_EN)
        else $error("bias on without logic power");
    back_needs_bias_a: assert property (O_PANEL_BACKLIGHT_EN |-> O_PANEL_BIAS_POWER_EN)
        else $error("backlight on without bias");
    bias_spacing_a: assert property ($rose(O_PANEL_LOGIC_POWER_EN) |-> s_bias_wait)
        else $error("bias follows logic power too soon");
    back_spacing_a: assert property ($rose(O_PANEL_BIAS_POWER_EN) |-> s_back_wait)
        else $error("backlight follows bias too soon");
    // Panel reset clears the enables; only a bus write sets them again
    reset_clear_a: assert property ($fell(I_PANEL_RESET_N) |-> ##[1:10] !O_REFRESH_EN)
        else $error("refresh not stopped by panel reset");
    reen_by_sw_a: assert property ($rose(O_REFRESH_EN) |->
        $past(O_WB_ACK) || $past(O_WB_ACK, 2) || $past(O_WB_ACK, 3))
        else $error("refresh restored without a write");
endmodule : ppm_props

//--- tb/ppm_sys_model.sv
// System power control side of the panel power pins
`timescale 1ns/100ps
module ppm_sys_model (
    input  wire logic i_clock,
    input  wire logic i_act_req,
    input  wire logic i_rst_req,
    input  wire logic i_ac_req,
    input  wire logic i_susp_req,
    input  wire logic i_stby_req,
    input  wire logic i_stby_out,
    input  wire logic i_stby_oe_n,
    output logic      o_activity,
    output logic      o_panel_reset_n,
    output logic      o_ac_power,
    output logic      o_suspend,
    output logic      o_standby
);
    // Idle levels: activity grounded, reset pulled up, AC pulled down
    initial
    begin
        o_activity = 1'b0;
        o_panel_reset_n = 1'b1;
        o_ac_power = 1'b0;
        o_suspend = 1'b0;
    end
    // Pins move just after the clock edge
    always @(posedge i_clock)
    begin
        o_activity <= i_act_req;
        o_panel_reset_n <= !i_rst_req;
        o_ac_power <= i_ac_req;
        o_suspend <= i_susp_req;
    end
    // Standby wire: block drives it when enabled, else the system
    assign o_standby = i_stby_oe_n ? i_stby_req : i_stby_out;
endmodule : ppm_sys_model

//--- tb/tb.sv
// Self-checking bench for the panel power management pin logic
`timescale 1ns/100ps
module tb;
    import ppm_pkg::*;
    localparam int SEQ = 2;
    localparam int DEB = 2;
    localparam int TC = PPM_TICK_CYC;
    localparam int X_LOG = 0, X_BIAS = 1, X_BACK = 2, X_STBY = 3, X_REFR = 4, X_IRQ = 5, X_SUSP = 6;
    logic        clk, rst, cyc, stb, we, ack, irq, stby, oe_n, back, bias, lpow, refr, susp;
    logic        act_q, rst_q, ac_q, susp_q, stby_q, act, prst_n, ac, spin, stby_pin;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, q;
    logic [6:0]  ov;
    int          errors, tests_run;
    assign ov = {susp, irq, refr, stby, back, bias, lpow};
    // Clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ppm_top #(.DEB_STEP_TICKS(DEB), .SEQ_STEP_TICKS(SEQ)) u_dut (
        .I_CLOCK(clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
        .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_ACTIVITY_SENSE_IN(act),
        .I_PANEL_RESET_N(prst_n), .I_AC_POWER_PRESENT(ac), .I_SUSPEND(spin), .I_STANDBY(stby_pin),
        .O_STANDBY(stby), .O_STANDBY_OE_N(oe_n), .O_PANEL_BACKLIGHT_EN(back), .O_PANEL_LOGIC_POWER_EN(lpow),
        .O_PANEL_BIAS_POWER_EN(bias), .O_REFRESH_EN(refr), .O_SUSPEND_MODE(susp), .O_IRQ(irq));
    ppm_sys_model u_sys (
        .i_clock(clk), .i_act_req(act_q), .i_rst_req(rst_q), .i_ac_req(ac_q), .i_susp_req(susp_q),
        .i_stby_req(stby_q), .i_stby_out(stby), .i_stby_oe_n(oe_n), .o_activity(act),
        .o_panel_reset_n(prst_n), .o_ac_power(ac), .o_suspend(spin), .o_standby(stby_pin));
    task automatic test_done();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // One classic Wishbone cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        chk(32'(ack), 32'h1);
        if (ack !== 1'b1)
            test_done();
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q & m, e);
    endtask : rd
    // Wait, bounded, for one output to reach a level
    task automatic wt(input int i, input logic v, input int mx);
        int n;
        n = 0;
        while (ov[i] !== v && n < mx)
        begin
            @(posedge clk);
            n++;
        end
        chk(32'(ov[i]), 32'(v));
        if (ov[i] !== v)
            test_done();
    endtask : wt
    task automatic pulse_act();
        act_q <= 1'b1;
        repeat (4) @(posedge clk);
        act_q <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : pulse_act
    task automatic t_regs();
        chk(32'(oe_n), 32'h1);
        chk(32'(ov), 32'h0);
        rd(PPM_OFS_CTRL, 32'hff, 32'(PPM_CTRL_RST));
        rd(PPM_OFS_DEBOUNCE, 32'hf, 32'(PPM_DEBOUNCE_RST));
        rd(PPM_OFS_SEQCFG, 32'hff, 32'(PPM_SEQCFG_RST));
        wb(1'b1, 8'h20, 32'hff);
        rd(8'h20, 32'hffffffff, 32'h0);
        sel <= 4'he;
        wb(1'b1, PPM_OFS_DEBOUNCE, 32'h3);
        sel <= 4'hf;
        rd(PPM_OFS_DEBOUNCE, 32'hf, 32'h0);
    endtask : t_regs
    task automatic t_up();
        wb(1'b1, PPM_OFS_CTRL, 32'h50);
        wt(X_LOG, 1'b1, 10);
        repeat (SEQ * TC / 2) @(posedge clk);
        chk(32'(bias), 32'h0);
        wt(X_BIAS, 1'b1, (SEQ + 1) * TC);
        wt(X_BACK, 1'b1, (SEQ + 1) * TC + 20);
        chk(32'(refr), 32'h1);
    endtask : t_up
    task automatic t_prst();
        wb(1'b1, PPM_OFS_IRQ_CLR, 32'h3f);
        wb(1'b1, PPM_OFS_IRQ_EN, 32'h2);
        rst_q <= 1'b1;
        wt(X_REFR, 1'b0, 10);
        rd(PPM_OFS_CTRL, 32'h60, 32'h0);
        wt(X_LOG, 1'b0, 3 * SEQ * TC + 50);
        chk(32'(irq), 32'h1);
        rst_q <= 1'b0;
        repeat (10) @(posedge clk);
        rd(PPM_OFS_CTRL, 32'h60, 32'h0);
        wb(1'b1, PPM_OFS_IRQ_EN, 32'h0);
        wt(X_IRQ, 1'b0, 3);
        rd(PPM_OFS_STATUS, 32'h2, 32'h2);
        wb(1'b1, PPM_OFS_IRQ_CLR, 32'h2);
        rd(PPM_OFS_STATUS, 32'h2, 32'h0);
        wb(1'b1, PPM_OFS_CTRL, 32'h50);
        wt(X_REFR, 1'b1, 5);
        wt(X_BACK, 1'b1, 2 * (SEQ + 1) * TC + 50);
    endtask : t_prst
    // Timer held by AC power resumes from its count
    task automatic t_timer();
        wb(1'b1, PPM_OFS_TIMER, 32'h5);
        rd(PPM_OFS_TIMER, 32'hffff, 32'h5);
        pulse_act();
        repeat (300) @(posedge clk);
        ac_q <= 1'b1;
        repeat (1000) @(posedge clk);
        chk(32'(back), 32'h1);
        ac_q <= 1'b0;
        wt(X_BACK, 1'b0, 400);
        wb(1'b1, PPM_OFS_TIMER, 32'h0);
    endtask : t_timer
    task automatic t_stby();
        pulse_act();
        wt(X_STBY, 1'b0, 20);
        chk(32'(oe_n), 32'h1);
        stby_q <= 1'b1;
        wt(X_STBY, 1'b1, 20);
        stby_q <= 1'b0;
        wb(1'b1, PPM_OFS_CTRL, 32'hd0);
        repeat (3) @(posedge clk);
        chk(32'(oe_n), 32'h0);
        chk(32'(stby_pin), 32'h1);
        pulse_act();
        wt(X_STBY, 1'b0, 20);
        chk(32'(stby_pin), 32'h0);
        wb(1'b1, PPM_OFS_CTRL, 32'h50);
    endtask : t_stby
    // Debounce restarts on a glitch; polarity swaps the active level
    task automatic t_susp();
        wb(1'b1, PPM_OFS_DEBOUNCE, 32'h2);
        susp_q <= 1'b1;
        repeat (200) @(posedge clk);
        chk(32'(susp), 32'h0);
        susp_q <= 1'b0;
        repeat (2) @(posedge clk);
        susp_q <= 1'b1;
        repeat (250) @(posedge clk);
        chk(32'(susp), 32'h0);
        wt(X_SUSP, 1'b1, 300);
        susp_q <= 1'b0;
        wt(X_SUSP, 1'b0, 600);
        wb(1'b1, PPM_OFS_SEQCFG, 32'h8);
        wt(X_SUSP, 1'b1, 600);
        wb(1'b1, PPM_OFS_CTRL, 32'h58);
        wt(X_SUSP, 1'b0, 5);
        wt(X_LOG, 1'b0, 3 * (SEQ + 1) * TC);
        wb(1'b1, PPM_OFS_CTRL, 32'h50);
        wb(1'b1, PPM_OFS_SEQCFG, 32'h0);
        wt(X_SUSP, 1'b0, 600);
    endtask : t_susp
    // Main sequence
    initial
    begin
        errors = 0;
        tests_run = 0;
        rst = 1'b1;
        {cyc, stb, we, act_q, rst_q, ac_q, susp_q, stby_q} = 8'h00;
        adr = 8'h00;
        sel = 4'hf;
        wdat = 32'h0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_up();
        t_prst();
        t_timer();
        t_stby();
        t_susp();
        test_done();
    end
endmodule : tb
bind ppm_top ppm_props #(.DEB_STEP_TICKS(DEB_STEP_TICKS), .SEQ_STEP_TICKS(SEQ_STEP_TICKS)) u_props (
    .I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE),
    .I_WB_ADR(I_WB_ADR), .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK),
    .I_ACTIVITY_SENSE_IN(I_ACTIVITY_SENSE_IN), .I_PANEL_RESET_N(I_PANEL_RESET_N),
    .I_AC_POWER_PRESENT(I_AC_POWER_PRESENT), .I_SUSPEND(I_SUSPEND), .I_STANDBY(I_STANDBY),
    .O_STANDBY(O_STANDBY), .O_STANDBY_OE_N(O_STANDBY_OE_N), .O_PANEL_BACKLIGHT_EN(O_PANEL_BACKLIGHT_EN),
    .O_PANEL_LOGIC_POWER_EN(O_PANEL_LOGIC_POWER_EN), .O_PANEL_BIAS_POWER_EN(O_PANEL_BIAS_POWER_EN),
    .O_REFRESH_EN(O_REFRESH_EN), .O_SUSPEND_MODE(O_SUSPEND_MODE), .O_IRQ(O_IRQ));
